// ### hw/dcpu_pkg.sv
package dcpu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned DCPU_AW = 32;
  localparam int unsigned DCPU_OPW = 8;
  localparam int unsigned DCPU_MODW = 7;
  localparam int unsigned DCPU_CNTW = 2;

  ////////////////////////////////////////////////////////////////////////////
  // opcodes of the preload forms, decimal 209 to 212
  localparam logic [DCPU_OPW-1:0] DCPU_OP_DISP = 8'hD1;
  localparam logic [DCPU_OPW-1:0] DCPU_OP_REG = 8'hD2;
  localparam logic [DCPU_OPW-1:0] DCPU_OP_HALF = 8'hD3;
  localparam logic [DCPU_OPW-1:0] DCPU_OP_WORD = 8'hD4;

  ////////////////////////////////////////////////////////////////////////////
  // address forming
  localparam logic [DCPU_AW-1:0] DCPU_BLOCK_BYTES = 32'h00000040;
  localparam logic [DCPU_AW-1:0] DCPU_ONE = 32'h00000001;
  localparam logic [4:0] DCPU_HALF_SHIFT = 5'h01;
  localparam logic [4:0] DCPU_WORD_SHIFT = 5'h02;
  localparam logic [4:0] DCPU_DISP_SHIFT = 5'h02;
  localparam int unsigned DCPU_GUARD_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // outstanding block fetches
  localparam logic [DCPU_CNTW-1:0] DCPU_MAX_OUTST = 2'h2;
  localparam logic [DCPU_CNTW-1:0] DCPU_CNT_STEP = 2'h1;
  localparam logic [DCPU_CNTW-1:0] DCPU_CNT_ZERO = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic valid;
    logic [DCPU_OPW-1:0] opcode;
    logic [DCPU_AW-1:0] base_operand;
    logic [DCPU_AW-1:0] index_operand;
    logic [DCPU_MODW-1:0] modifier;
    logic guard_present;
    logic [DCPU_AW-1:0] guard_value;
  } dcpu_issue_t;

  typedef struct packed {
    logic valid;
    logic [DCPU_AW-1:0] addr;
  } dcpu_req_t;

  typedef struct packed {
    dcpu_req_t lookup;
    dcpu_req_t fetch;
    logic [DCPU_CNTW-1:0] outst;
    logic drop_hit;
    logic drop_busy;
  } dcpu_state_t;

  localparam dcpu_state_t DCPU_STATE_RST = '0;

endpackage

// ### hw/dcpu_preload.sv
`timescale 1ns/1ps

module dcpu_preload
  import dcpu_pkg::*;
#(
  parameter logic [DCPU_AW-1:0] BLOCK_BYTES = DCPU_BLOCK_BYTES
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire dcpu_issue_t issue,
  input wire logic lookup_hit,
  input wire logic demand_miss_start,
  input wire logic fill_done,
  output dcpu_req_t lookup,
  output dcpu_req_t fetch,
  output logic [DCPU_CNTW-1:0] outst_count,
  output logic drop_hit,
  output logic drop_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // decode and address functions

  function automatic logic is_preload(input logic [DCPU_OPW-1:0] op);
    return (op == DCPU_OP_HALF) || (op == DCPU_OP_WORD) ||
           (op == DCPU_OP_DISP) || (op == DCPU_OP_REG);
  endfunction

  function automatic logic guard_ok(input dcpu_issue_t i);
    return !i.guard_present || i.guard_value[DCPU_GUARD_BIT];
  endfunction

  // signed modifier in steps of four
  function automatic logic [DCPU_AW-1:0] disp_of(
    input logic [DCPU_MODW-1:0] m
  );
    logic signed [DCPU_AW-1:0] s;
    s = DCPU_AW'(signed'(m));
    return s <<< DCPU_DISP_SHIFT;
  endfunction

  function automatic logic [DCPU_AW-1:0] align(input logic [DCPU_AW-1:0] a);
    return a & ~(BLOCK_BYTES - DCPU_ONE);
  endfunction

  function automatic logic [DCPU_AW-1:0] eff_addr(input dcpu_issue_t i);
    logic [DCPU_AW-1:0] sum;
    unique case (i.opcode)
      DCPU_OP_HALF: begin
        sum = i.base_operand + (i.index_operand << DCPU_HALF_SHIFT);
      end
      DCPU_OP_WORD: begin
        sum = i.base_operand + (i.index_operand << DCPU_WORD_SHIFT);
      end
      DCPU_OP_DISP: begin
        sum = i.base_operand + disp_of(i.modifier);
      end
      default: begin
        sum = i.base_operand + i.index_operand;
      end
    endcase
    return align(sum);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  dcpu_state_t state_q;
  dcpu_state_t state_d;
  logic [DCPU_CNTW-1:0] cnt_base;
  logic busy;
  logic take;

  always_comb begin
    state_d = state_q;
    state_d.drop_hit = 1'b0;
    state_d.drop_busy = 1'b0;
    state_d.fetch.valid = 1'b0;

    // stage 0: accept a guarded preload, look its block up
    take = issue.valid && is_preload(issue.opcode) && guard_ok(issue);
    state_d.lookup.valid = take;
    if (take) begin
      state_d.lookup.addr = eff_addr(issue);
    end

    cnt_base = state_q.outst;
    if (fill_done && cnt_base != DCPU_CNT_ZERO) begin
      cnt_base = cnt_base - DCPU_CNT_STEP;
    end
    if (demand_miss_start && cnt_base != DCPU_MAX_OUTST) begin
      cnt_base = cnt_base + DCPU_CNT_STEP;
    end
    // demand misses in this same cycle win the slot over a preload
    busy = (cnt_base == DCPU_MAX_OUTST);

    // stage 1: decide on the lookup answer
    if (state_q.lookup.valid) begin
      if (lookup_hit) begin
        state_d.drop_hit = 1'b1;
      end else if (busy) begin
        // dropped, never stalls the issue side
        state_d.drop_busy = 1'b1;
      end else begin
        // fire and forget, nobody waits on the fill
        state_d.fetch.valid = 1'b1;
        state_d.fetch.addr = state_q.lookup.addr;
        cnt_base = cnt_base + DCPU_CNT_STEP;
      end
    end
    state_d.outst = cnt_base;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= DCPU_STATE_RST;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign lookup = state_q.lookup;
  assign fetch = state_q.fetch;
  assign outst_count = state_q.outst;
  assign drop_hit = state_q.drop_hit;
  assign drop_busy = state_q.drop_busy;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  chk_half_addr: assert property (
    issue.valid && issue.opcode == DCPU_OP_HALF && guard_ok(issue)
    |=> lookup.valid && lookup.addr == align($past(issue.base_operand)
      + ($past(issue.index_operand) << 1)))
    else $error("halfword indexed address wrong");

  chk_word_addr: assert property (
    issue.valid && issue.opcode == DCPU_OP_WORD && guard_ok(issue)
    |=> lookup.valid && lookup.addr == align($past(issue.base_operand)
      + ($past(issue.index_operand) << 2)))
    else $error("word indexed address wrong");

  chk_disp_addr: assert property (
    issue.valid && issue.opcode == DCPU_OP_DISP && guard_ok(issue)
    |=> lookup.valid && lookup.addr == align($past(issue.base_operand)
      + {{23{$past(issue.modifier[6])}}, $past(issue.modifier), 2'b00}))
    else $error("displacement address wrong");

  chk_reg_addr: assert property (
    issue.valid && issue.opcode == DCPU_OP_REG && guard_ok(issue)
    |=> lookup.valid && lookup.addr == align($past(issue.base_operand)
      + $past(issue.index_operand)))
    else $error("register indexed address wrong");

  chk_block_align: assert property (
    fetch.valid |-> (fetch.addr & (BLOCK_BYTES - DCPU_ONE)) == '0)
    else $error("fetch address not block aligned");

  chk_hit_drop: assert property (
    lookup.valid && lookup_hit |=> !fetch.valid && drop_hit)
    else $error("cached block was fetched again");

  chk_outst_max: assert property (
    outst_count <= DCPU_MAX_OUTST)
    else $error("more than two fetches outstanding");

  chk_busy_drop: assert property (
    lookup.valid && !lookup_hit && outst_count == DCPU_MAX_OUTST
      && !fill_done |=> !fetch.valid && drop_busy)
    else $error("preload not dropped while two misses live");

  chk_miss_fetch: assert property (
    lookup.valid && !lookup_hit && outst_count == DCPU_CNT_ZERO
    |=> fetch.valid && fetch.addr == $past(lookup.addr) ##1 !fetch.valid)
    else $error("free slot but no single fetch pulse");

  chk_guard_off: assert property (
    issue.guard_present && !issue.guard_value[0] |=> !lookup.valid)
    else $error("guarded off preload went ahead");

  chk_bad_opcode: assert property (
    !is_preload(issue.opcode) |=> !lookup.valid ##1 !fetch.valid)
    else $error("non preload opcode was executed");

endmodule

// ### verif/dcpu_cache_model.sv
`timescale 1ns/1ps
module dcpu_cache_model
  import dcpu_pkg::*;
(
  input wire logic core_clk,
  input wire dcpu_req_t lookup,
  input wire logic [DCPU_AW-1:0] cached_addr,
  output logic lookup_hit
);
  // toggles so a stale hit level never looks valid
  logic toggle_q = 1'b0;
  always_ff @(posedge core_clk) begin
    toggle_q <= ~toggle_q;
  end
  assign lookup_hit = lookup.valid ? (lookup.addr == cached_addr) : toggle_q;
endmodule

// ### verif/dcpu_preload_tb.sv
`timescale 1ns/1ps
module dcpu_preload_tb;
  import dcpu_pkg::*;
  logic core_clk, arst_n, lookup_hit, demand_miss_start, fill_done;
  logic drop_hit, drop_busy;
  logic [DCPU_CNTW-1:0] outst_count;
  logic [DCPU_AW-1:0] cached_addr;
  dcpu_issue_t issue;
  dcpu_req_t lookup, fetch;
  int fail_count, checks, cycles;
  dcpu_preload dcpu_preload_inst (.core_clk(core_clk), .arst_n(arst_n),
    .issue(issue), .lookup_hit(lookup_hit),
    .demand_miss_start(demand_miss_start), .fill_done(fill_done),
    .lookup(lookup), .fetch(fetch), .outst_count(outst_count),
    .drop_hit(drop_hit), .drop_busy(drop_busy));
  dcpu_cache_model dcpu_cache_model_inst (.core_clk(core_clk),
    .lookup(lookup), .cached_addr(cached_addr), .lookup_hit(lookup_hit));
  ////////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // kind: 0 fetch, 1 hit drop, 2 busy drop, 3 ignored
  task op(input logic [7:0] opc, input logic [31:0] b, input logic [31:0] ix,
    input logic [6:0] m, input logic [1:0] g, input int kind,
    input logic [31:0] ea);
    issue = {1'b1, opc, b, ix, m, g[1], {31'h7FFFFFFF, g[0]}};
    @(negedge core_clk);
    issue.valid = 1'b0;
    chk("lookup_valid", {31'h0, kind != 3}, {31'h0, lookup.valid});
    if (kind != 3) chk("lookup_addr", ea, lookup.addr);
    @(negedge core_clk);
    chk("fetch_valid", {31'h0, kind == 0}, {31'h0, fetch.valid});
    chk("drop_hit", {31'h0, kind == 1}, {31'h0, drop_hit});
    chk("drop_busy", {31'h0, kind == 2}, {31'h0, drop_busy});
    if (kind == 0) chk("fetch_addr", ea, fetch.addr);
  endtask
  task pulse(input logic dm, input logic fd);
    demand_miss_start = dm;
    fill_done = fd;
    @(negedge core_clk);
    demand_miss_start = 1'b0;
    fill_done = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_forms;
    op(DCPU_OP_HALF, 32'h0000ABCD, 32'hC, 7'h00, 2'b00, 0, 32'h0000ABC0);
    pulse(1'b0, 1'b1);
    op(DCPU_OP_WORD, 32'h0000ABCD, 32'hD, 7'h00, 2'b11, 0, 32'h0000AC00);
    pulse(1'b0, 1'b1);
    op(DCPU_OP_DISP, 32'h0000ABFF, 32'h3F, 7'h01, 2'b11, 0, 32'h0000AC00);
    pulse(1'b0, 1'b1);
    op(DCPU_OP_DISP, 32'h00000100, 32'hFC0, 7'h40, 2'b00, 0, 32'h0);
    pulse(1'b0, 1'b1);
    op(DCPU_OP_REG, 32'h0000ABCD, 32'hD, 7'h00, 2'b00, 0, 32'h0000ABC0);
    pulse(1'b0, 1'b1);
    op(DCPU_OP_REG, 32'hFFFFFFF0, 32'h7F, 7'h00, 2'b00, 0, 32'h40);
    pulse(1'b0, 1'b1);
    chk("outst_count", 32'h0, {30'h0, outst_count});
    $display("forms done");
  endtask
  task t_busy;
    op(DCPU_OP_HALF, 32'h00002000, 32'h0, 7'h00, 2'b00, 0, 32'h00002000);
    pulse(1'b1, 1'b0);
    chk("outst_count", 32'h2, {30'h0, outst_count});
    op(DCPU_OP_REG, 32'h00004000, 32'h0, 7'h00, 2'b00, 2, 32'h00004000);
    chk("outst_count", 32'h2, {30'h0, outst_count});
    pulse(1'b0, 1'b1);
    pulse(1'b0, 1'b1);
    pulse(1'b0, 1'b1);
    chk("outst_count", 32'h0, {30'h0, outst_count});
    $display("busy done");
  endtask
  task t_drop;
    cached_addr = 32'h00005000;
    op(DCPU_OP_DISP, 32'h00005004, 32'h0, 7'h00, 2'b00, 1, 32'h00005000);
    op(DCPU_OP_HALF, 32'h0000ABCD, 32'hC, 7'h00, 2'b10, 3, 32'h0);
    op(8'hD5, 32'h0000ABCD, 32'hC, 7'h00, 2'b00, 3, 32'h0);
    op(8'hD0, 32'h0000ABCD, 32'hC, 7'h00, 2'b00, 3, 32'h0);
    chk("outst_count", 32'h0, {30'h0, outst_count});
    $display("drop done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // generous ceiling, the tests need some 50 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      complete_run;
    end
  end
  initial begin
    arst_n = 1'b0;
    issue = '0;
    demand_miss_start = 1'b0;
    fill_done = 1'b0;
    cached_addr = 32'hFFFFFFC0;
    repeat (12) @(negedge core_clk);
    arst_n = 1'b1;
    @(negedge core_clk);
    t_forms;
    t_busy;
    t_drop;
    complete_run;
  end
endmodule
